// ### inc/sps_pkg.sv
package sps_pkg;
    // Clock period and timing figures.
    localparam int CLK_PERIOD_NS = 8;
    localparam int IRQ_DELAY_NS = 160;
    localparam int IRQ_DELAY_CYC = (IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_FETCH_NS = 240;
    // Internal fetch takes well under the master's wait so plain reads stay safe.
    localparam int FETCH_CYC = (READ_FETCH_NS / CLK_PERIOD_NS) / 2;
    // Register offsets (byte addresses on APB).
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_EVENT = 8'h10;
    localparam logic [7:0] OFS_IRQ_REQ = 8'h14;
    localparam logic [7:0] OFS_RDATA = 8'h18;
    localparam logic [7:0] OFS_LAST_ADDR = 8'h1C;
    localparam logic [7:0] OFS_LAST_WDATA = 8'h20;
    // Control fields.
    localparam int CTRL_BUSY_OE = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_LATE = 3;
    // Interrupt status bits.
    localparam int EV_ACCESS_DONE = 0;
    localparam int EV_ACCESS_ERR = 1;
    localparam int EV_WRITE = 2;
    localparam int EV_NUM = 3;
    // Commands.
    localparam logic [2:0] CMD_NOP = 3'h0;
    localparam logic [2:0] CMD_READ = 3'h2;
    localparam logic [2:0] CMD_READ_WS = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_ADDR_EXT = 3'h6;
    localparam logic [7:0] TERM_BYTE = 8'hFF;
    typedef enum logic [1:0] {
        SPS_ADDR = 2'b00,
        SPS_READ = 2'b01,
        SPS_WRITE = 2'b10,
        SPS_IGNORE = 2'b11
    } sps_phase_e;
endpackage

// ### verilog/sps_slave.sv
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module sps_slave (
    // System.
    input wire logic clk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Serial link.
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    output logic spi_irq
);
    import sps_pkg::*;

    logic [2:0] sel_s, clk_s, di_s;
    logic sel, sel_d, sclk_q, sclk_d, din;
    // two flops, then edge detection on the stable copy.
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_s <= 3'h7;
            clk_s <= 3'h0;
            di_s <= 3'h0;
        end else begin
            sel_s <= {sel_s[1:0], sel_n};
            clk_s <= {clk_s[1:0], sclk};
            di_s <= {di_s[1:0], serial_in};
        end
    end
    assign sel = ~sel_s[1];
    assign sel_d = ~sel_s[2];
    assign sclk_q = clk_s[1];
    assign sclk_d = clk_s[2];
    assign din = di_s[1];

    // Control register.
    logic busy_oe_en, late_sample;
    logic [1:0] spi_mode;
    logic [31:0] ctrl;
    assign busy_oe_en = ctrl[CTRL_BUSY_OE];
    assign spi_mode = ctrl[CTRL_MODE_LO +: 2];
    assign late_sample = ctrl[CTRL_LATE];

    // Mode 0/3 sample on rising, 1/2 on falling edge; output changes on the other one.
    logic cpha_pol, rise, fall, sample_edge, shift_edge;
    assign rise = sclk_q & ~sclk_d;
    assign fall = ~sclk_q & sclk_d;
    assign cpha_pol = spi_mode[0] ^ spi_mode[1];
    assign sample_edge = sel & (cpha_pol ? fall : rise);
    assign shift_edge = sel & (cpha_pol ? rise : fall);

    logic mode02_normal;
    assign mode02_normal = ~spi_mode[0] & ~late_sample;

    sps_phase_e phase;
    logic [2:0] bitcnt;
    logic [7:0] rx_sh, byte_idx;
    logic [15:0] addr;
    logic [2:0] cmd;
    logic byte_done, last_cmd_byte;
    logic [7:0] tx_sh;
    logic fetching, fetched, busy_drive;
    logic [7:0] fetch_cnt;
    logic term_seen, err, status_ok, access_end;
    logic [23:0] irq_req;
    logic [7:0] rd_data, last_wdata;
    logic [15:0] last_addr;
    logic [7:0] rx_byte;
    logic have_clock, three_byte;
    logic [2:0] next_cmd;
    logic fetched_used;

    assign rx_byte = {rx_sh[6:0], din};
    assign byte_done = sample_edge && bitcnt == 3'h7;
    assign access_end = sel_d & ~sel;

    // Receive shifter and command decode.
    always_ff @(posedge clk) begin
        if (rst || !sel) begin
            bitcnt <= 3'h0;
            rx_sh <= 8'h00;
            byte_idx <= 8'h00;
            phase <= SPS_ADDR;
            addr <= 16'h0000;
            cmd <= CMD_NOP;
            three_byte <= 1'b0;
            have_clock <= 1'b0;
        end else if (sample_edge) begin
            have_clock <= 1'b1;
            bitcnt <= bitcnt + 3'h1;
            rx_sh <= rx_byte;
            if (bitcnt == 3'h7) begin
                byte_idx <= byte_idx + 8'h01;
                if (phase == SPS_ADDR) begin
                    if (byte_idx == 8'h00) begin
                        addr[12:5] <= rx_byte;
                    end else if (byte_idx == 8'h01) begin
                        addr[4:0] <= rx_byte[7:3];
                        cmd <= rx_byte[2:0];
                        three_byte <= rx_byte[2:0] == CMD_ADDR_EXT;
                    end else begin
                        addr[15:13] <= rx_byte[7:5];
                        cmd <= rx_byte[4:2];
                    end
                end
                if (phase == SPS_ADDR && last_cmd_byte) begin
                    phase <= (next_cmd == CMD_WRITE) ? SPS_WRITE :
                             (next_cmd == CMD_READ || next_cmd == CMD_READ_WS) ? SPS_READ : SPS_IGNORE;
                end
            end
        end
    end

    // Command carried by the byte being completed now.
    always_comb begin
        next_cmd = CMD_NOP;
        last_cmd_byte = 1'b0;
        if (byte_idx == 8'h01) begin
            next_cmd = rx_byte[2:0];
            last_cmd_byte = rx_byte[2:0] != CMD_ADDR_EXT;
        end else if (byte_idx >= 8'h02) begin
            next_cmd = rx_byte[4:2];
            last_cmd_byte = rx_byte[4:2] != CMD_ADDR_EXT;
        end
    end

    // Read fetch: first byte takes FETCH_CYC cycles, following bytes are prefetched.
    logic cmd_done_pulse, in_ws;
    assign cmd_done_pulse = byte_done && phase == SPS_ADDR && last_cmd_byte &&
                            (next_cmd == CMD_READ || next_cmd == CMD_READ_WS);
    always_ff @(posedge clk) begin
        if (rst || !sel) begin
            fetching <= 1'b0;
            fetched <= 1'b0;
            fetch_cnt <= 8'h00;
            in_ws <= 1'b0;
        end else if (cmd_done_pulse) begin
            fetching <= 1'b1;
            fetch_cnt <= 8'(FETCH_CYC);
            in_ws <= next_cmd == CMD_READ_WS;
        end else if (fetching) begin
            fetch_cnt <= fetch_cnt - 8'h01;
            if (fetch_cnt == 8'h01) begin
                fetching <= 1'b0;
                fetched <= 1'b1;
            end
        end else if (byte_done && phase == SPS_READ && in_ws) begin
            in_ws <= 1'b0;
        end
    end

    // Busy drive starts at the first shift edge after the command byte.
    always_ff @(posedge clk) begin
        if (rst || !sel) begin
            busy_drive <= 1'b0;
        end else if (phase == SPS_READ && busy_oe_en && !busy_drive && shift_edge && bitcnt == 3'h0 &&
                     !fetched_used) begin
            busy_drive <= 1'b1;
        end else if (busy_drive && (sample_edge || (fetched && din))) begin
            // The master withdraws busy by raising serial_in after the fetch, so bit 7 is up before its sample.
            busy_drive <= 1'b0;
        end
    end
    // Errors: partial byte, clock while busy, missing termination, reads past termination.
    always_ff @(posedge clk) begin
        if (rst || (sel && !sel_d)) begin
            err <= 1'b0;
            term_seen <= 1'b0;
            fetched_used <= 1'b0;
        end else begin
            if (sample_edge && fetching && !in_ws)
                err <= 1'b1;
            if (byte_done && phase == SPS_READ && !in_ws) begin
                fetched_used <= 1'b1;
                if (term_seen)
                    err <= 1'b1;
                term_seen <= rx_byte == TERM_BYTE;
            end
            if (access_end && (bitcnt != 3'h0 || (phase == SPS_READ && fetched_used && !term_seen)))
                err <= 1'b1;
        end
    end

    // Status of the last clocked access holds until the next clocked access ends.
    always_ff @(posedge clk) begin
        if (rst) begin
            status_ok <= 1'b1;
        end else if (access_end && have_clock) begin
            status_ok <= ~(err | (bitcnt != 3'h0));
        end
    end

    // Transmit shifter.
    logic [7:0] next_tx;
    always_comb begin
        case (byte_idx)
            // The byte index has already moved on when the next byte is loaded.
            8'h01: next_tx = irq_req[15:8];
            8'h02: next_tx = three_byte ? irq_req[23:16] : rd_data;
            default: next_tx = rd_data;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst || !sel) begin
            tx_sh <= 8'h00;
        end else if (sel && !sel_d) begin
            tx_sh <= irq_req[7:0];
        end else if (shift_edge) begin
            if (bitcnt == 3'h0 && have_clock)
                tx_sh <= next_tx;
            else if (have_clock)
                tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end

    // Pin drivers from flops; first bit before any clock is status in non 0/2-normal modes.
    always_ff @(posedge clk) begin
        if (rst) begin
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out_oe <= sel;
            if (!sel)
                serial_out <= 1'b0;
            else if (!have_clock)
                serial_out <= mode02_normal ? irq_req[7] : status_ok;
            else if (busy_drive)
                serial_out <= fetching;
            else
                serial_out <= tx_sh[7];
        end
    end

    // Event delay line keeps the interrupt pin behind the request registers.
    logic [23:0] ev_pend;
    logic [7:0] irq_cnt;
    logic [31:0] ev_wr;
    logic ev_strobe;
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_req <= 24'h000000;
            irq_cnt <= 8'h00;
            spi_irq <= 1'b0;
        end else begin
            if (ev_strobe) begin
                irq_req <= pwdata[23:0];
                irq_cnt <= (pwdata[23:0] != 24'h000000) ? 8'(IRQ_DELAY_CYC) : 8'h00;
                if (pwdata[23:0] == 24'h000000)
                    spi_irq <= 1'b0;
            end else if (irq_cnt != 8'h00) begin
                irq_cnt <= irq_cnt - 8'h01;
                if (irq_cnt == 8'h01)
                    spi_irq <= 1'b1;
            end
        end
    end

    // APB register file, zero wait states.
    logic [EV_NUM-1:0] ev_stat, ev_mask, ev_set;
    logic apb_wr, apb_rd;
    assign apb_wr = psel & penable & pwrite;
    assign apb_rd = psel & penable & ~pwrite;
    assign ev_strobe = apb_wr && paddr == OFS_EVENT;
    assign ev_set[EV_ACCESS_DONE] = access_end & have_clock;
    assign ev_set[EV_ACCESS_ERR] = access_end & have_clock & (err | (bitcnt != 3'h0));
    assign ev_set[EV_WRITE] = byte_done & (phase == SPS_WRITE);

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= 32'h00000000;
            ev_mask <= '0;
            rd_data <= 8'h00;
        end else if (apb_wr) begin
            case (paddr)
                OFS_CTRL: ctrl <= pwdata;
                OFS_IRQ_MASK: ev_mask <= pwdata[EV_NUM-1:0];
                OFS_RDATA: rd_data <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Sticky status, cleared by reading it; a same-cycle event wins.
    always_ff @(posedge clk) begin
        if (rst)
            ev_stat <= '0;
        else if (apb_rd && paddr == OFS_IRQ_STAT)
            ev_stat <= ev_set;
        else
            ev_stat <= ev_stat | ev_set;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            last_addr <= 16'h0000;
            last_wdata <= 8'h00;
        end else begin
            if (phase == SPS_WRITE || phase == SPS_READ)
                last_addr <= addr;
            if (ev_set[EV_WRITE])
                last_wdata <= rx_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq <= |(ev_stat & ev_mask);
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable) begin
                case (paddr)
                    OFS_CTRL: prdata <= ctrl;
                    OFS_STATUS: prdata <= {26'h0, status_ok, busy_drive, fetching, phase, sel};
                    OFS_IRQ_STAT: prdata <= {29'h0, ev_stat | ev_set};
                    OFS_IRQ_MASK: prdata <= {29'h0, ev_mask};
                    OFS_EVENT: prdata <= {8'h00, irq_req};
                    OFS_IRQ_REQ: prdata <= {31'h0, spi_irq};
                    OFS_RDATA: prdata <= {24'h0, rd_data};
                    OFS_LAST_ADDR: prdata <= {16'h0, last_addr};
                    OFS_LAST_WDATA: prdata <= {24'h0, last_wdata};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule // sps_slave
`default_nettype wire

// ### dv/sps_slave_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module sps_slave_assertions
    import sps_pkg::*;
(
    // System.
    input wire logic clk,
    input wire logic rst,
    // APB.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    // Serial link.
    input wire logic sel_n,
    input wire logic serial_out_oe,
    input wire logic spi_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic acc;
    logic [7:0] ev_age;
    logic [7:0] clr_age;
    assign acc = psel && penable && pready;
    // Ages rest at 8'hFF so a long idle never looks like a recent cause.
    always_ff @(posedge clk) begin
        if (rst) begin
            ev_age <= 8'hFF;
        end else if (acc && pwrite && paddr == OFS_EVENT) begin
            ev_age <= 8'h00;
        end else if (ev_age != 8'hFF) begin
            ev_age <= ev_age + 8'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            clr_age <= 8'hFF;
        end else if (acc && (pwrite ? paddr == OFS_IRQ_MASK : paddr == OFS_IRQ_STAT)) begin
            clr_age <= 8'h00;
        end else if (clr_age != 8'hFF) begin
            clr_age <= clr_age + 8'h01;
        end
    end
    sel_release_a: assert property (sel_n [*4] |-> !serial_out_oe)
        else $error("serial output driven while deselected");
    sel_drive_a: assert property (!sel_n [*6] |-> serial_out_oe)
        else $error("serial output not driven after select");
    irq_lag_a: assert property ($rose(spi_irq) |-> ev_age >= IRQ_DELAY_CYC - 1 && ev_age <= 8'h28)
        else $error("event interrupt rose too early or with no event");
    irq_follow_a: assert property (acc && pwrite && paddr == OFS_EVENT && pwdata[23:0] != 24'h0
        |-> ##[19:26] spi_irq)
        else $error("event interrupt missing after event");
    irq_clear_a: assert property ($fell(spi_irq) |-> ev_age <= 8'h04)
        else $error("event interrupt fell without a write");
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("apb access phase not answered at once");
    apb_phase_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    apb_refuse_a: assert property (acc && !pwrite && paddr > OFS_LAST_WDATA |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    apb_accept_a: assert property (acc && paddr <= OFS_LAST_WDATA && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    int_drop_a: assert property ($fell(irq) |-> clr_age <= 8'h03)
        else $error("interrupt fell without clear or mask");
    reset_quiet_a: assert property ($fell(rst) |-> !irq && !spi_irq && !serial_out_oe)
        else $error("outputs active after reset");
endmodule // sps_slave_assertions
bind sps_slave sps_slave_assertions u_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .sel_n(sel_n), .serial_out_oe(serial_out_oe), .spi_irq(spi_irq)
);
`default_nettype wire

// ### dv/sps_spi_master.sv
`timescale 1ns/1ns
`default_nettype none
module sps_spi_master (
    // Serial link.
    output var logic sel_n,
    output var logic sclk,
    output var logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic held;
    logic miso;
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b1;
        held = 1'b0;
    end
    // A released line keeps no value, so the model reads the inverse of the last bit.
    always @(serial_out, serial_out_oe) begin
        if (serial_out_oe) begin
            held = serial_out;
        end
    end
    assign miso = serial_out_oe ? serial_out : ~held;
    // The settle time also covers the status becoming valid and the gap between accesses.
    task automatic select(input logic on);
        if (!on) begin
            #40;
        end
        sel_n <= !on;
        #200;
    endtask
    // Mode 0: 80 ns period, slave shifts on the falling edge, master samples on the rising one.
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            serial_in <= tx[i];
            #40;
            sclk <= 1'b1;
            rx[i] = miso;
            #40;
            sclk <= 1'b0;
        end
    endtask
    task automatic read_gap();
        #240;
    endtask
endmodule // sps_spi_master
`default_nettype wire

// ### dv/spi_slave_busy_status_timing_test.sv
`timescale 1ns/1ns
`default_nettype none
module spi_slave_busy_status_timing_test;
    import sps_pkg::*;
    logic clk = 1'b0;
    logic rst, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready, pslverr, irq, sel_n, sclk, serial_in, serial_out, serial_out_oe, spi_irq;
    logic [31:0] rd;
    logic er;
    logic [7:0] rx;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    int first_hi;
    always #4 clk = ~clk;
    sps_slave i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .sel_n(sel_n), .sclk(sclk), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .spi_irq(spi_irq));
    sps_spi_master i_master (.sel_n(sel_n), .sclk(sclk), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_pin(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_chk("ctrl reset", OFS_CTRL, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk_pin("unmapped refused", 1'b1, er);
        apb(1'b1, OFS_IRQ_MASK, 32'h7);
        apb(1'b1, OFS_RDATA, 32'hC3C3C3C3);
        apb(1'b1, OFS_EVENT, 32'h003C9625);
        repeat (15) @(posedge clk);
        chk_pin("event irq early", 1'b0, spi_irq);
        repeat (10) @(posedge clk);
        chk_pin("event irq", 1'b1, spi_irq);
        $display("test registers done");
        i_master.select(1'b1);
        chk_pin("first bit", 1'b0, serial_out);
        chk_pin("driven", 1'b1, serial_out_oe);
        i_master.shift(8'h00, 8, rx);
        chk("irq byte 0", 32'h25, {24'h0, rx});
        i_master.shift({5'h00, CMD_READ}, 8, rx);
        chk("irq byte 1", 32'h96, {24'h0, rx});
        i_master.read_gap();
        i_master.shift(TERM_BYTE, 8, rx);
        chk("read byte", 32'hC3, {24'h0, rx});
        i_master.select(1'b0);
        chk_pin("released", 1'b0, serial_out_oe);
        chk_pin("irq pending", 1'b1, irq);
        rd_chk("done event", OFS_IRQ_STAT, 32'h1);
        repeat (3) @(posedge clk);
        chk_pin("irq cleared", 1'b0, irq);
        $display("test plain read done");
        i_master.select(1'b1);
        i_master.shift(8'h00, 8, rx);
        i_master.shift({5'h00, CMD_READ_WS}, 8, rx);
        i_master.shift(TERM_BYTE, 8, rx);
        i_master.shift(TERM_BYTE, 8, rx);
        chk("ws read byte", 32'hC3, {24'h0, rx});
        i_master.select(1'b0);
        i_master.select(1'b1);
        i_master.shift(8'h12, 8, rx);
        i_master.shift({5'h03, CMD_WRITE}, 8, rx);
        i_master.shift(8'h5A, 8, rx);
        i_master.select(1'b0);
        rd_chk("write data", OFS_LAST_WDATA, 32'h5A);
        rd_chk("write addr", OFS_LAST_ADDR, 32'h243);
        rd_chk("write event", OFS_IRQ_STAT, 32'h5);
        rd_chk("status reg", OFS_STATUS, 32'h20);
        $display("test wait state and write done");
        apb(1'b1, OFS_CTRL, 32'h8);
        i_master.select(1'b1);
        chk_pin("status good", 1'b1, serial_out);
        i_master.shift(8'h00, 3, rx);
        i_master.select(1'b0);
        i_master.select(1'b1);
        chk_pin("status bad", 1'b0, serial_out);
        i_master.select(1'b0);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("error event", 32'h2, rd & 32'h2);
        $display("test status done");
        apb(1'b1, OFS_CTRL, 32'h1);
        i_master.select(1'b1);
        i_master.shift(8'h00, 8, rx);
        i_master.shift({5'h00, CMD_READ}, 8, rx);
        first_hi = -1;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            if (serial_out === 1'b1 && first_hi < 0) begin
                first_hi = n;
            end
        end
        chk_pin("busy window", 1'b1, first_hi >= 4 && first_hi <= 16);
        chk_pin("busy done", 1'b0, serial_out);
        i_master.shift(TERM_BYTE, 8, rx);
        chk("busy read byte", 32'hC3, {24'h0, rx});
        i_master.select(1'b0);
        $display("test busy read done");
        repeat (3) @(posedge clk);
        chk_pin("irq before mask", 1'b1, irq);
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        repeat (3) @(posedge clk);
        chk_pin("irq masked", 1'b0, irq);
        rd_chk("sticky done", OFS_IRQ_STAT, 32'h1);
        apb(1'b1, OFS_EVENT, 32'h0);
        repeat (5) @(posedge clk);
        chk_pin("event irq off", 1'b0, spi_irq);
        $display("test interrupts done");
        wrap_up();
    end
endmodule // spi_slave_busy_status_timing_test
`default_nettype wire
